// file: sc_regs_cfg.svh
// Constants for the system control and status register bank.
// Assumes a 10 MHz mclk and a 32-bit AXI4-Lite register bus.
`ifndef SC_REGS_CFG_SVH
`define SC_REGS_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SC_IDX_PIN_DRIVE        10'h0bc
`define SC_IDX_CLOCK_SOURCE     10'h0bd
`define SC_IDX_WATCHDOG_EN      10'h0be
`define SC_IDX_LINK_PROTOCOL    10'h0bf
`define SC_IDX_EEPROM_CONTROL   10'h0c0
`define SC_IDX_STATUS           10'h0c1
`define SC_IDX_WATCHDOG_SERVICE 10'h0c8

// ****************************************************************
// Reset values
// ****************************************************************
`define SC_RST_PIN_DRIVE        6'h00
`define SC_RST_CLOCK_SOURCE     2'h0
`define SC_RST_WATCHDOG_EN      2'h0
`define SC_RST_LINK_PROTOCOL    1'h0

// ****************************************************************
// Field positions
// ****************************************************************
`define SC_PIN_TOP              2
`define SC_PIN_MID              1
`define SC_WD_SOFTWARE_BIT      1
`define SC_WD_OSCILLATOR_BIT    0
`define SC_EE_RELOAD_BIT        1
`define SC_EE_PROGRAM_BIT       0
`define SC_ST_TRIM_FAIL         6
`define SC_ST_RAM_INCOMPLETE    5
`define SC_ST_RAM_FAILED        4
`define SC_ST_SUPPLY_OV         3
`define SC_ST_ANALOG_UV         2
`define SC_ST_ANALOG_OC         1
`define SC_ST_BIAS_OC           0

// ****************************************************************
// Timing and limits
// ****************************************************************
`define SC_MCLK_HZ              10000000
`define SC_SW_WD_PERIOD_MS      250
`define SC_SW_WD_CYCLES         (`SC_SW_WD_PERIOD_MS * (`SC_MCLK_HZ / 1000))
`define SC_SCI_MAX_BYTES        4'h8
`define SC_RESP_OKAY            2'h0
`define SC_RESP_SLVERR          2'h2

`endif

// file: sc_regs_pkg.sv
// Types shared by the system control and status register bank.
// Assumes nothing beyond a SystemVerilog tool.
package sc_regs_pkg;

  typedef enum logic [1:0] {
    SC_CLK_INTERNAL_NOSYNC,
    SC_CLK_INTERNAL_SYNC,
    SC_CLK_EXTERNAL
  } sc_clkmode_t;

  typedef struct packed {
    logic [7:0] stage1;
    logic [7:0] stage2;
  } sc_sync_state_t;

  typedef struct packed {
    logic [21:0] count;
    logic        core_reset;
  } sc_wd_state_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [9:0]  aw_idx;
    logic [7:0]  wbyte;
    logic        wbyte_en;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [5:0]  pin_drive;
    logic [1:0]  clock_source;
    logic [1:0]  watchdog_en;
    logic        link_protocol;
    logic        eeprom_busy;
    logic        eeprom_reload;
    logic        eeprom_program_start;
    logic        watchdog_service;
    logic        pin_one_strong;
    logic        pin_two_strong;
    sc_clkmode_t clock_mode;
    logic        sci_mode;
    logic [3:0]  sci_byte_limit;
  } sc_top_state_t;

endpackage

// file: sc_sync2.sv
// Two-stage synchroniser for eight level inputs from other domains.
// Assumes the inputs are slow levels; no pulse is shorter than a cycle.
`timescale 1ns/1ns
module sc_sync2
  import sc_regs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);

  sc_sync_state_t st_q;
  sc_sync_state_t st_d;

  // First stage feeds only the second stage
  always_comb begin
    st_d        = st_q;
    st_d.stage1 = async_in;
    st_d.stage2 = st_q.stage1;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stage2;

endmodule // sc_sync2

// file: sc_watchdog.sv
// Software and oscillator watchdogs that request a core reset.
// Assumes synchronised enables and oscillator fault, and a service pulse.
`timescale 1ns/1ns
`include "sc_regs_cfg.svh"
module sc_watchdog
  import sc_regs_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `SC_SW_WD_CYCLES
) (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic software_enable,
  input  wire logic oscillator_enable,
  input  wire logic service,
  input  wire logic osc_fault,
  output logic      core_reset
);

  sc_wd_state_t st_q;
  sc_wd_state_t st_d;

  always_comb begin
    st_d            = st_q;
    st_d.core_reset = 1'b0;
    if (!software_enable || service) begin
      st_d.count = '0;
    end else if (st_q.count >= 22'(TIMEOUT_CYCLES - 1)) begin
      // Missed service: one reset pulse, then start a fresh period
      st_d.count      = '0;
      st_d.core_reset = 1'b1; // see RULE_09
    end else begin
      st_d.count = st_q.count + 22'h000001;
    end
    // Held for as long as the oscillator stays out of range
    if (oscillator_enable && osc_fault) begin
      st_d.core_reset = 1'b1; // see RULE_08
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign core_reset = st_q.core_reset;

endmodule // sc_watchdog

// file: sc_regs_top.sv
// System control and status register bank on an AXI4-Lite slave.
// Assumes analog flags and self-test results arrive asynchronously and
// the EEPROM controller reports completion on the mclk domain.
`timescale 1ns/1ns
`include "sc_regs_cfg.svh"

// Overview of operation
// RULE_01 - Pin two top config bit 0 selects weak pull-up.
// RULE_02 - Pin two top and middle bits both 1 select strong pull-up.
// RULE_03 - Pin one top config bit 0 selects weak pull-up.
// RULE_04 - Pin one top and middle bits both 1 select strong pull-up.
// RULE_05 - Software must not program pin one code 101; reserved.
// RULE_06 - Clock codes 00, 11 internal no sync; 10 crystal; reset 00.
// RULE_07 - Clock code 01 runs internal clock and processes sync pulses.
// RULE_08 - Enabled oscillator watchdog resets core on bad oscillator.
// RULE_09 - Enabled software watchdog resets core if not served in 250ms.
// RULE_10 - Watchdog enables: software bit 1, oscillator bit 0, reset 0.
// RULE_11 - Link select 0 runs LIN protocol, 1 buffered SCI; reset 0.
// RULE_12 - Buffered SCI moves at most eight bytes per transfer.
// RULE_13 - Writing 1 to reload bit copies EEPROM into cache.
// RULE_14 - Writing 1 to bit 0 starts EEPROM programming from cache.
// RULE_15 - Bit 0 reads 1 while programming, drops to 0 on completion; code keeps it 1 if bit 0 is written 1 in that cycle.
// RULE_16 - Status bit 6 shows trim corruption.
// RULE_17 - Status bit 5 is 0 when RAM self-test completed, else 1.
// RULE_18 - Status bit 4 is 0 when RAM self-test passed, else 1.
// RULE_19 - Status bits 3..0: overvoltage, undervoltage, overcurrents.
// RULE_20 - Supply fault inputs pass a two-stage synchroniser first.
module sc_regs_top
  import sc_regs_pkg::*;
#(
  parameter int SW_WD_TIMEOUT_CYCLES = `SC_SW_WD_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        supply_overvoltage,
  input  wire logic        analog_supply_undervoltage,
  input  wire logic        analog_supply_overcurrent,
  input  wire logic        bias_overcurrent,
  input  wire logic        trim_corrupted,
  input  wire logic        ram_selftest_completed,
  input  wire logic        ram_selftest_passed,
  input  wire logic        oscillator_out_of_range,
  input  wire logic        eeprom_program_done,
  output logic             pin_one_strong,
  output logic             pin_two_strong,
  output sc_clkmode_t      clock_mode,
  output logic             sci_mode,
  output logic [3:0]       sci_byte_limit,
  output logic             eeprom_reload,
  output logic             eeprom_program_start,
  output logic             core_reset
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [7:0] sync_flags;
  logic [7:0] status_byte;
  logic       osc_fault;

  sc_sync2 u_sync (
    .mclk     (mclk),
    .arst_n   (arst_n),
    .async_in ({oscillator_out_of_range, trim_corrupted,
                ram_selftest_completed, ram_selftest_passed,
                supply_overvoltage, analog_supply_undervoltage,
                analog_supply_overcurrent, bias_overcurrent}), // see RULE_20
    .sync_out (sync_flags)
  );

  assign osc_fault = sync_flags[7];

  // A self-test that never started reports both incomplete and failed
  always_comb begin
    status_byte                        = 8'h00;
    status_byte[`SC_ST_TRIM_FAIL]      = sync_flags[6];  // see RULE_16
    status_byte[`SC_ST_RAM_INCOMPLETE] = ~sync_flags[5]; // see RULE_17
    status_byte[`SC_ST_RAM_FAILED]     = ~sync_flags[4]; // see RULE_18
    status_byte[`SC_ST_SUPPLY_OV]      = sync_flags[3];  // see RULE_19
    status_byte[`SC_ST_ANALOG_UV]      = sync_flags[2];  // see RULE_19
    status_byte[`SC_ST_ANALOG_OC]      = sync_flags[1];  // see RULE_19
    status_byte[`SC_ST_BIAS_OC]        = sync_flags[0];  // see RULE_19
  end

  // ****************************************************************
  // State
  // ****************************************************************
  sc_top_state_t st_q;
  sc_top_state_t st_d;

  logic [9:0] ar_idx;
  logic       do_write;

  assign ar_idx   = s_axi_araddr[11:2];
  assign do_write = st_q.aw_got && st_q.w_got && !st_q.bvalid;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d                      = st_q;
    st_d.eeprom_reload        = 1'b0;
    st_d.eeprom_program_start = 1'b0;
    st_d.watchdog_service     = 1'b0;

    // Write address and data are taken independently, in any order
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_got = 1'b1;
      st_d.aw_idx = s_axi_awaddr[11:2];
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_got    = 1'b1;
      st_d.wbyte    = s_axi_wdata[7:0];
      st_d.wbyte_en = s_axi_wstrb[0];
    end

    // Programming ends when the EEPROM controller reports completion
    if (eeprom_program_done) begin
      st_d.eeprom_busy = 1'b0; // see RULE_15
    end

    if (do_write) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = `SC_RESP_OKAY;
      unique case (st_q.aw_idx)
        `SC_IDX_PIN_DRIVE: begin
          // Code 101 on pin one is left to software to avoid
          if (st_q.wbyte_en) begin
            st_d.pin_drive = st_q.wbyte[5:0]; // see RULE_05
          end
        end
        `SC_IDX_CLOCK_SOURCE: begin
          if (st_q.wbyte_en) begin
            st_d.clock_source = st_q.wbyte[1:0]; // see RULE_06
          end
        end
        `SC_IDX_WATCHDOG_EN: begin
          if (st_q.wbyte_en) begin
            st_d.watchdog_en = st_q.wbyte[1:0]; // see RULE_10
          end
        end
        `SC_IDX_LINK_PROTOCOL: begin
          if (st_q.wbyte_en) begin
            st_d.link_protocol = st_q.wbyte[0]; // see RULE_11
          end
        end
        `SC_IDX_EEPROM_CONTROL: begin
          if (st_q.wbyte_en && st_q.wbyte[`SC_EE_RELOAD_BIT]) begin
            st_d.eeprom_reload = 1'b1; // see RULE_13
          end
          // A start while busy is ignored; the set wins over done
          if (st_q.wbyte_en && st_q.wbyte[`SC_EE_PROGRAM_BIT]) begin
            if (!st_q.eeprom_busy) begin
              st_d.eeprom_program_start = 1'b1; // see RULE_14
            end
            st_d.eeprom_busy = 1'b1; // see RULE_15
          end
        end
        `SC_IDX_STATUS: begin
          // Read-only; writes are accepted and dropped
        end
        `SC_IDX_WATCHDOG_SERVICE: begin
          st_d.watchdog_service = st_q.wbyte_en; // see RULE_09
        end
        default: begin
          st_d.bresp = `SC_RESP_SLVERR;
        end
      endcase
    end

    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    // Only one write in flight: hold both channels until the answer
    st_d.awready = !st_d.aw_got && !st_d.bvalid;
    st_d.wready  = !st_d.w_got && !st_d.bvalid;

    // Read channel: data registered one cycle after the address
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = `SC_RESP_OKAY;
      st_d.rdata  = 32'h00000000;
      unique case (ar_idx)
        `SC_IDX_PIN_DRIVE: begin
          st_d.rdata[5:0] = st_q.pin_drive;
        end
        `SC_IDX_CLOCK_SOURCE: begin
          st_d.rdata[1:0] = st_q.clock_source;
        end
        `SC_IDX_WATCHDOG_EN: begin
          st_d.rdata[1:0] = st_q.watchdog_en;
        end
        `SC_IDX_LINK_PROTOCOL: begin
          st_d.rdata[0] = st_q.link_protocol;
        end
        `SC_IDX_EEPROM_CONTROL: begin
          // Reload is write-only and reads back as 0
          st_d.rdata[`SC_EE_PROGRAM_BIT] = st_q.eeprom_busy; // see RULE_15
        end
        `SC_IDX_STATUS: begin
          st_d.rdata[7:0] = status_byte;
        end
        `SC_IDX_WATCHDOG_SERVICE: begin
        end
        default: begin
          st_d.rresp = `SC_RESP_SLVERR;
        end
      endcase
    end
    st_d.arready = !st_d.rvalid;

    // Pin drive decode; codes not listed fall back to weak pull-up
    st_d.pin_one_strong = st_d.pin_drive[`SC_PIN_TOP]
                       && st_d.pin_drive[`SC_PIN_MID]; // see RULE_03, RULE_04
    st_d.pin_two_strong = st_d.pin_drive[3 + `SC_PIN_TOP]
                       && st_d.pin_drive[3 + `SC_PIN_MID]; // see RULE_01, RULE_02

    unique case (st_d.clock_source)
      2'h1:    st_d.clock_mode = SC_CLK_INTERNAL_SYNC;   // see RULE_07
      2'h2:    st_d.clock_mode = SC_CLK_EXTERNAL;        // see RULE_06
      default: st_d.clock_mode = SC_CLK_INTERNAL_NOSYNC; // see RULE_06
    endcase

    st_d.sci_mode       = st_d.link_protocol; // see RULE_11
    st_d.sci_byte_limit = st_d.link_protocol ? `SC_SCI_MAX_BYTES
                                             : 4'h0; // see RULE_12
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q               <= '0;
      st_q.pin_drive     <= `SC_RST_PIN_DRIVE;
      st_q.clock_source  <= `SC_RST_CLOCK_SOURCE;
      st_q.watchdog_en   <= `SC_RST_WATCHDOG_EN;
      st_q.link_protocol <= `SC_RST_LINK_PROTOCOL;
      st_q.clock_mode    <= SC_CLK_INTERNAL_NOSYNC;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Watchdogs
  // ****************************************************************
  sc_watchdog #(
    .TIMEOUT_CYCLES (SW_WD_TIMEOUT_CYCLES)
  ) u_watchdog (
    .mclk              (mclk),
    .arst_n            (arst_n),
    .software_enable   (st_q.watchdog_en[`SC_WD_SOFTWARE_BIT]),
    .oscillator_enable (st_q.watchdog_en[`SC_WD_OSCILLATOR_BIT]),
    .service           (st_q.watchdog_service),
    .osc_fault         (osc_fault), // see RULE_08
    .core_reset        (core_reset)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign s_axi_awready        = st_q.awready;
  assign s_axi_wready         = st_q.wready;
  assign s_axi_bvalid         = st_q.bvalid;
  assign s_axi_bresp          = st_q.bresp;
  assign s_axi_arready        = st_q.arready;
  assign s_axi_rvalid         = st_q.rvalid;
  assign s_axi_rdata          = st_q.rdata;
  assign s_axi_rresp          = st_q.rresp;
  assign pin_one_strong       = st_q.pin_one_strong;
  assign pin_two_strong       = st_q.pin_two_strong;
  assign clock_mode           = st_q.clock_mode;
  assign sci_mode             = st_q.sci_mode;
  assign sci_byte_limit       = st_q.sci_byte_limit;
  assign eeprom_reload        = st_q.eeprom_reload;
  assign eeprom_program_start = st_q.eeprom_program_start;

endmodule // sc_regs_top

// file: sc_regs_props.sv
// Concurrent checks on the register bank's ports.
// Assumes it is bound into sc_regs_top and sees only its ports.
`timescale 1ns/1ns
module sc_regs_props
  import sc_regs_pkg::*;
(
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pin_one_strong,
  input wire logic        pin_two_strong,
  input sc_clkmode_t      clock_mode,
  input wire logic        sci_mode,
  input wire logic [3:0]  sci_byte_limit,
  input wire logic        eeprom_reload,
  input wire logic        eeprom_program_start
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_arready_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answering");
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_sci_limit: assert property (
    sci_byte_limit == (sci_mode ? 4'h8 : 4'h0))
    else $error("byte limit does not follow mode");
  chk_reload_pulse: assert property (
    eeprom_reload |-> $rose(s_axi_bvalid) ##1 !eeprom_reload)
    else $error("reload pulse wrong");
  chk_start_pulse: assert property (
    eeprom_program_start |-> $rose(s_axi_bvalid) ##1 !eeprom_program_start)
    else $error("program start pulse wrong");
  chk_pin_change: assert property (
    $changed(pin_one_strong) || $changed(pin_two_strong)
    |-> $rose(s_axi_bvalid))
    else $error("pin drive changed without a write");
  chk_mode_change: assert property (
    $changed(clock_mode) || $changed(sci_mode) |-> $rose(s_axi_bvalid))
    else $error("mode changed without a write");
endmodule // sc_regs_props

bind sc_regs_top sc_regs_props u_props (
  .mclk(mclk), .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .pin_one_strong(pin_one_strong), .pin_two_strong(pin_two_strong),
  .clock_mode(clock_mode), .sci_mode(sci_mode),
  .sci_byte_limit(sci_byte_limit), .eeprom_reload(eeprom_reload),
  .eeprom_program_start(eeprom_program_start));

// file: sc_regs_test.sv
// Self-checking bench for the register bank over AXI4-Lite.
// Assumes sc_regs_top with a 40-cycle software watchdog timeout.
`timescale 1ns/1ns
`include "sc_regs_cfg.svh"
module sc_regs_test
  import sc_regs_pkg::*;
;
  logic        mclk, arst_n, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, osc_bad, ee_done;
  logic        pin1, pin2, sci, ee_rl, ee_st, core_rst;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, sci_lim;
  logic [1:0]  bresp, rresp, resp;
  logic [6:0]  flags;
  logic [5:0]  p;
  sc_clkmode_t cmode;
  int          n_errors = 0, comparisons = 0, cycles = 0;
  int          n_rl = 0, n_st = 0, n_core = 0, k;

  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  sc_regs_top #(.SW_WD_TIMEOUT_CYCLES(40)) u_dut (
    .mclk(mclk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .supply_overvoltage(flags[3]), .analog_supply_undervoltage(flags[2]),
    .analog_supply_overcurrent(flags[1]), .bias_overcurrent(flags[0]),
    .trim_corrupted(flags[6]), .ram_selftest_completed(~flags[5]),
    .ram_selftest_passed(~flags[4]), .oscillator_out_of_range(osc_bad),
    .eeprom_program_done(ee_done), .pin_one_strong(pin1),
    .pin_two_strong(pin2), .clock_mode(cmode), .sci_mode(sci),
    .sci_byte_limit(sci_lim), .eeprom_reload(ee_rl),
    .eeprom_program_start(ee_st), .core_reset(core_rst));

  // ****************************************************************
  // Bus tasks and reporting
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ready is registered, so its value at the falling edge is the value
  // sampled at the next rising edge.
  task automatic wr(input logic [9:0] idx, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_hit, w_hit, b_hit;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hit = 1'b0;
    while (!b_hit) begin
      @(negedge mclk);
      aw_hit = awvalid & awready;
      w_hit = wvalid & wready;
      b_hit = bvalid;
      resp = bresp;
      @(posedge mclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    check("bresp", 32'(resp), 32'(er));
  endtask

  task automatic rd_chk(input string what, input logic [9:0] idx,
                        input logic [31:0] exp, input logic [1:0] er);
    logic a_hit, r_hit;
    logic [31:0] d;
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hit = 1'b0;
    while (!r_hit) begin
      @(negedge mclk);
      a_hit = arvalid & arready;
      r_hit = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge mclk);
      if (a_hit) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    check(what, d, exp);
    check("rresp", 32'(resp), 32'(er));
  endtask

  task automatic conclude();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Pulse counters read pre-update values, so no race with the design
  always @(posedge mclk) begin
    cycles++;
    if (ee_rl === 1'b1) n_rl++;
    if (ee_st === 1'b1) n_st++;
    if (core_rst === 1'b1) n_core++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    arst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 12'h000; araddr = 12'h000;
    wdata = 32'h0; wstrb = 4'hf; flags = 7'h00; osc_bad = 1'b0;
    ee_done = 1'b0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    rd_chk("clk_sel", `SC_IDX_CLOCK_SOURCE, 32'h0, `SC_RESP_OKAY);
    rd_chk("watchdog_enables", `SC_IDX_WATCHDOG_EN, 32'h0, `SC_RESP_OKAY);
    rd_chk("link", `SC_IDX_LINK_PROTOCOL, 32'h0, `SC_RESP_OKAY);
    rd_chk("eeprom_control", `SC_IDX_EEPROM_CONTROL, 32'h0, `SC_RESP_OKAY);
    rd_chk("status", `SC_IDX_STATUS, 32'h0, `SC_RESP_OKAY);
    rd_chk("unmapped", 10'h0c2, 32'h0, `SC_RESP_SLVERR);
    wr(10'h0c2, 32'hff, `SC_RESP_SLVERR);
    for (int c = 0; c < 8; c++) begin
      p = {3'(c), ~3'(c)};
      if (p[2:0] == 3'h5) p[0] = 1'b0;
      wr(`SC_IDX_PIN_DRIVE, {26'h0, p}, `SC_RESP_OKAY);
      @(negedge mclk);
      check("pin_one", 32'(pin1), 32'(p[2] & p[1]));
      check("pin_two", 32'(pin2), 32'(p[5] & p[4]));
      rd_chk("pin_drive", `SC_IDX_PIN_DRIVE, 32'(p), `SC_RESP_OKAY);
    end
    for (int c = 0; c < 4; c++) begin
      wr(`SC_IDX_CLOCK_SOURCE, 32'hfc | c, `SC_RESP_OKAY);
      @(negedge mclk);
      check("clock_mode", 32'(cmode), (c == 1) ? 32'(SC_CLK_INTERNAL_SYNC) :
            (c == 2) ? 32'(SC_CLK_EXTERNAL) : 32'(SC_CLK_INTERNAL_NOSYNC));
      rd_chk("clk_sel", `SC_IDX_CLOCK_SOURCE, 32'(c), `SC_RESP_OKAY);
    end
    for (int c = 1; c >= 0; c--) begin
      wr(`SC_IDX_LINK_PROTOCOL, 32'(c), `SC_RESP_OKAY);
      @(negedge mclk);
      check("sci_mode", 32'(sci), 32'(c));
      check("sci_limit", 32'(sci_lim), c ? 32'h8 : 32'h0);
      rd_chk("link", `SC_IDX_LINK_PROTOCOL, 32'(c), `SC_RESP_OKAY);
    end
    wr(`SC_IDX_EEPROM_CONTROL, 32'h2, `SC_RESP_OKAY);
    @(negedge mclk);
    check("reloads", 32'(n_rl), 32'h1);
    check("starts", 32'(n_st), 32'h0);
    rd_chk("eeprom_control", `SC_IDX_EEPROM_CONTROL, 32'h0, `SC_RESP_OKAY);
    // Second start lands while busy and must not start again
    for (int i = 0; i < 2; i++) begin
      wr(`SC_IDX_EEPROM_CONTROL, 32'h1, `SC_RESP_OKAY);
      @(negedge mclk);
      check("starts", 32'(n_st), 32'h1);
      rd_chk("ee_busy", `SC_IDX_EEPROM_CONTROL, 32'h1, `SC_RESP_OKAY);
    end
    @(posedge mclk) ee_done <= 1'b1;
    @(posedge mclk) ee_done <= 1'b0;
    rd_chk("ee_idle", `SC_IDX_EEPROM_CONTROL, 32'h0, `SC_RESP_OKAY);
    wr(`SC_IDX_EEPROM_CONTROL, 32'h0, `SC_RESP_OKAY);
    @(negedge mclk);
    check("pulses", 32'(n_st + n_rl), 32'h2);
    for (int b = 0; b < 7; b++) begin
      @(posedge mclk) flags <= 7'(1 << b);
      repeat (4) @(posedge mclk);
      rd_chk("status", `SC_IDX_STATUS, 32'(1 << b), `SC_RESP_OKAY);
    end
    @(posedge mclk) flags <= 7'h00;
    repeat (4) @(posedge mclk);
    wr(`SC_IDX_STATUS, 32'hff, `SC_RESP_OKAY);
    rd_chk("status_ro", `SC_IDX_STATUS, 32'h0, `SC_RESP_OKAY);
    wr(`SC_IDX_WATCHDOG_SERVICE, 32'h1, `SC_RESP_OKAY);
    wr(`SC_IDX_WATCHDOG_EN, 32'h2, `SC_RESP_OKAY);
    rd_chk("watchdog_enables", `SC_IDX_WATCHDOG_EN, 32'h2, `SC_RESP_OKAY);
    k = n_core;
    for (int i = 0; i < 8; i++) begin
      wr(`SC_IDX_WATCHDOG_SERVICE, 32'h1, `SC_RESP_OKAY);
      repeat (20) @(posedge mclk);
    end
    check("wd_served", 32'(n_core), 32'(k));
    repeat (60) @(posedge mclk);
    check("wd_fired", 32'(n_core > k), 32'h1);
    wr(`SC_IDX_WATCHDOG_EN, 32'h1, `SC_RESP_OKAY);
    @(posedge mclk) osc_bad <= 1'b1;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    check("osc_reset", 32'(core_rst), 32'h1);
    @(posedge mclk) osc_bad <= 1'b0;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    check("osc_clear", 32'(core_rst), 32'h0);
    wr(`SC_IDX_WATCHDOG_EN, 32'h0, `SC_RESP_OKAY);
    @(posedge mclk) osc_bad <= 1'b1;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    check("osc_off", 32'(core_rst), 32'h0);
    conclude();
  end
endmodule // sc_regs_test
